// ==== core/ppi_defines.svh ====
// Register offsets, field positions and reset values of the PWM polarity and period event block
`ifndef PPI_DEFINES_SVH
`define PPI_DEFINES_SVH
`define PPI_OFF_EVENT_CONTROL 8'hb7
`define PPI_OFF_OUTPUT_INVERT 8'hd6
`define PPI_OFF_MASK_ENABLE   8'hfb
`define PPI_OFF_MASK_LEVEL    8'hfc
`define PPI_OFF_EVENT_STATUS  8'hfd
`define PPI_OFF_EVENT_MASK    8'hfe
`define PPI_OFF_GEN_STATE     8'hff
`define PPI_CHAN_MSB          5
`define PPI_SEL_MSB           2
`define PPI_TYP_LSB           4
`define PPI_TYP_MSB           5
`define PPI_CTRL_MASK         8'h37
`define PPI_CHAN_MASK         8'h3f
`define PPI_RST_BYTE          8'h00
`define PPI_RST_CHAN          6'h00
`define PPI_MAX_SEL           3'h5
`define PPI_SEL_FALLBACK      3'h0
`define PPI_FLAG_BIT          0
`define PPI_ALL_CHAN          6'h3f
`endif

// ==== core/ppi_pkg.sv ====
// Types for the PWM polarity and period event block
`default_nettype none
package ppi_pkg;
  typedef enum logic [1:0] {
    PPI_EV_FALL   = 2'h0,
    PPI_EV_RISE   = 2'h1,
    PPI_EV_CENTRE = 2'h2,
    PPI_EV_END    = 2'h3
  } ppi_event_type;
endpackage : ppi_pkg
`default_nettype wire

// ==== core/ppi_top.sv ====
// PWM output polarity, masking and period event flag with a classic Wishbone slave
// Contract
// (R1) Invert bit one complements channel pin
// (R2) Invert bits reset to zero
// (R3) Selected period point sets event flag
// (R4) Flag stays set until software clears
// (R5) Type field selects fall, rise, centre, end
// (R6) Centre and end only when centre aligned
// (R7) Channel select above five means channel zero
// (R8) Mask level also passes through invert
// (R9) Edge found by comparing with previous level
//
// Decided for this implementation: the Wishbone slave port.
`include "ppi_defines.svh"
`default_nettype none
module ppi_top (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [7:0] wb_dat_i,
  input  wire logic       wb_we_i,
  input  wire logic       wb_sel_i,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  output logic      [7:0] wb_dat_o,
  output logic            wb_ack_o,
  input  wire logic [5:0] gen_i,
  input  wire logic       centre_aligned_i,
  input  wire logic       period_centre_i,
  input  wire logic       period_end_i,
  output logic      [5:0] pwm_o,
  output logic            irq_o
);
  logic [5:0] invert_q, invert_d;
  logic [5:0] menable_q, menable_d;
  logic [5:0] mlevel_q, mlevel_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic       flag_q, flag_d;
  logic       imask_q, imask_d;
  logic [5:0] gen_prev_q, gen_prev_d;
  logic [5:0] pwm_q, pwm_d;
  logic       irq_q, irq_d;
  logic [7:0] rdat_q, rdat_d;
  logic       ack_q, ack_d;
  logic       req, wr, event_hit, cur, prev;
  logic       clear_req;
  logic [1:0] typ;
  logic [2:0] sel;
  logic [5:0] stage;

  function automatic logic [2:0] chan_pick(input logic [2:0] code);
    chan_pick = (code > `PPI_MAX_SEL) ? `PPI_SEL_FALLBACK : code; // [R7]
  endfunction : chan_pick

  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr  = req && wb_we_i && wb_sel_i;
  assign clear_req = wr && wb_adr_i == `PPI_OFF_EVENT_STATUS && wb_dat_i[`PPI_FLAG_BIT];
  assign typ = ctrl_q[`PPI_TYP_MSB:`PPI_TYP_LSB];

  always_comb begin
    sel   = chan_pick(ctrl_q[`PPI_SEL_MSB:0]);
    cur   = gen_i[sel];
    prev  = gen_prev_q[sel];
    event_hit = 1'b0;
    unique case (ppi_pkg::ppi_event_type'(ctrl_q[`PPI_TYP_MSB:`PPI_TYP_LSB])) // [R5]
      ppi_pkg::PPI_EV_FALL:   event_hit = prev && !cur; // [R9]
      ppi_pkg::PPI_EV_RISE:   event_hit = !prev && cur; // [R9]
      ppi_pkg::PPI_EV_CENTRE: event_hit = centre_aligned_i && period_centre_i; // [R6]
      ppi_pkg::PPI_EV_END:    event_hit = centre_aligned_i && period_end_i; // [R6]
    endcase
    stage = (gen_i & ~menable_q) | (mlevel_q & menable_q);
    pwm_d = stage ^ invert_q; // [R1] [R8]
    gen_prev_d = gen_i;
    invert_d  = invert_q;
    menable_d = menable_q;
    mlevel_d  = mlevel_q;
    ctrl_d    = ctrl_q;
    imask_d   = imask_q;
    flag_d    = flag_q;
    if (clear_req) begin
      flag_d = 1'b0;
    end
    if (event_hit) begin
      flag_d = 1'b1; // [R3] [R4]
    end
    if (wr) begin
      unique case (wb_adr_i)
        `PPI_OFF_OUTPUT_INVERT: invert_d  = wb_dat_i[`PPI_CHAN_MSB:0]; // [R1]
        `PPI_OFF_EVENT_CONTROL: ctrl_d    = wb_dat_i & `PPI_CTRL_MASK;
        `PPI_OFF_MASK_ENABLE:   menable_d = wb_dat_i[`PPI_CHAN_MSB:0];
        `PPI_OFF_MASK_LEVEL:    mlevel_d  = wb_dat_i[`PPI_CHAN_MSB:0];
        `PPI_OFF_EVENT_MASK:    imask_d   = wb_dat_i[`PPI_FLAG_BIT];
        default: ;
      endcase
    end
    irq_d = flag_d && imask_d;
    ack_d = req;
    rdat_d = `PPI_RST_BYTE;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        `PPI_OFF_OUTPUT_INVERT: rdat_d = {2'h0, invert_q};
        `PPI_OFF_EVENT_CONTROL: rdat_d = ctrl_q;
        `PPI_OFF_MASK_ENABLE:   rdat_d = {2'h0, menable_q};
        `PPI_OFF_MASK_LEVEL:    rdat_d = {2'h0, mlevel_q};
        `PPI_OFF_EVENT_STATUS:  rdat_d = {7'h00, flag_q};
        `PPI_OFF_EVENT_MASK:    rdat_d = {7'h00, imask_q};
        `PPI_OFF_GEN_STATE:     rdat_d = {2'h0, pwm_q};
        default:                rdat_d = `PPI_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      invert_q   <= `PPI_RST_CHAN; // [R2]
      menable_q  <= `PPI_RST_CHAN;
      mlevel_q   <= `PPI_RST_CHAN;
      ctrl_q     <= `PPI_RST_BYTE;
      flag_q     <= 1'b0;
      imask_q    <= 1'b0;
      gen_prev_q <= `PPI_RST_CHAN;
      pwm_q      <= `PPI_RST_CHAN;
      irq_q      <= 1'b0;
      rdat_q     <= `PPI_RST_BYTE;
      ack_q      <= 1'b0;
    end else begin
      invert_q   <= invert_d;
      menable_q  <= menable_d;
      mlevel_q   <= mlevel_d;
      ctrl_q     <= ctrl_d;
      flag_q     <= flag_d;
      imask_q    <= imask_d;
      gen_prev_q <= gen_prev_d;
      pwm_q      <= pwm_d;
      irq_q      <= irq_d;
      rdat_q     <= rdat_d;
      ack_q      <= ack_d;
    end
  end

  assign pwm_o    = pwm_q;
  assign irq_o    = irq_q;
  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;

  sequence s_inv_write;
    wr && wb_adr_i == `PPI_OFF_OUTPUT_INVERT;
  endsequence

  sequence s_status_clear;
    clear_req && !event_hit;
  endsequence

  sequence s_bus_take;
    req;
  endsequence

  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  sequence s_centre_event;
    typ == ppi_pkg::PPI_EV_CENTRE && centre_aligned_i && period_centre_i;
  endsequence

  sequence s_end_event;
    typ == ppi_pkg::PPI_EV_END && centre_aligned_i && period_end_i;
  endsequence

  AST_POLARITY: assert property (@(posedge clk_i) disable iff (rst_i) // [R1] [R8]
    1'b1 |=> pwm_o == ($past(stage) ^ $past(invert_q)))
    else $error("Pin level does not follow polarity");

  AST_PIN_DIRECT: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    invert_q == `PPI_RST_CHAN && menable_q == `PPI_RST_CHAN |=> pwm_o == $past(gen_i))
    else $error("Pins not equal to generator with no inversion");

  AST_PIN_INVERT: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    invert_q == `PPI_ALL_CHAN && menable_q == `PPI_RST_CHAN |=> pwm_o == ~$past(gen_i))
    else $error("Pins not complement of generator with full inversion");

  AST_INV_RESET: assert property (@(posedge clk_i) // [R2]
    rst_i |=> invert_q == `PPI_RST_CHAN)
    else $error("Invert bits not cleared by reset");

  AST_PIN_RESET: assert property (@(posedge clk_i) // [R2]
    rst_i |=> pwm_o == `PPI_RST_CHAN)
    else $error("Pins not cleared by reset");

  AST_INV_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    s_inv_write |=> invert_q == $past(wb_dat_i[`PPI_CHAN_MSB:0]))
    else $error("Invert write not stored");

  AST_INV_KEEP: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    !(wr && wb_adr_i == `PPI_OFF_OUTPUT_INVERT) |=> $stable(invert_q))
    else $error("Invert bits changed without a write");

  AST_SEL_IGNORED: assert property (@(posedge clk_i) disable iff (rst_i)
    req && wb_we_i && !wb_sel_i && wb_adr_i == `PPI_OFF_OUTPUT_INVERT |=> $stable(invert_q))
    else $error("Write without byte select was stored");

  AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    event_hit |=> flag_q)
    else $error("Event did not set flag");

  AST_FLAG_CAUSE: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    !flag_q && !event_hit |=> !flag_q)
    else $error("Flag set without an event");

  AST_FLAG_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    flag_q && !clear_req |=> flag_q)
    else $error("Flag cleared without software");

  AST_FLAG_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    s_status_clear |=> !flag_q)
    else $error("Software clear of flag ignored");

  AST_SET_WINS: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    clear_req && event_hit |=> flag_q)
    else $error("Clear won over a new event");

  AST_NO_CENTRE_EDGE: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    !centre_aligned_i && ctrl_q[`PPI_TYP_MSB] |-> !event_hit)
    else $error("Centre or end event in edge aligned mode");

  AST_CENTRE_POINT: assert property (@(posedge clk_i) disable iff (rst_i) // [R5] [R6]
    s_centre_event |=> flag_q)
    else $error("Centre point event not flagged");

  AST_END_POINT: assert property (@(posedge clk_i) disable iff (rst_i) // [R5] [R6]
    s_end_event |=> flag_q)
    else $error("End point event not flagged");

  AST_CENTRE_ONLY: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    typ == ppi_pkg::PPI_EV_CENTRE |-> event_hit == (centre_aligned_i && period_centre_i))
    else $error("Centre type reacted to another point");

  AST_END_ONLY: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    typ == ppi_pkg::PPI_EV_END |-> event_hit == (centre_aligned_i && period_end_i))
    else $error("End type reacted to another point");

  AST_SEL_FALLBACK: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    ctrl_q[`PPI_SEL_MSB:0] > `PPI_MAX_SEL |-> sel == `PPI_SEL_FALLBACK)
    else $error("Invalid channel code not mapped to channel zero");

  AST_SEL_DIRECT: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    ctrl_q[`PPI_SEL_MSB:0] <= `PPI_MAX_SEL |-> sel == ctrl_q[`PPI_SEL_MSB:0])
    else $error("Valid channel code not used as given");

  AST_RISE_EDGE: assert property (@(posedge clk_i) disable iff (rst_i) // [R5] [R9]
    typ == ppi_pkg::PPI_EV_RISE && $rose(gen_i[sel]) && $stable(ctrl_q) |-> event_hit)
    else $error("Rising edge missed");

  AST_FALL_EDGE: assert property (@(posedge clk_i) disable iff (rst_i) // [R5] [R9]
    typ == ppi_pkg::PPI_EV_FALL && $fell(gen_i[sel]) && $stable(ctrl_q) |-> event_hit)
    else $error("Falling edge missed");

  AST_RISE_ONLY: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    typ == ppi_pkg::PPI_EV_RISE && (prev || !cur) |-> !event_hit)
    else $error("Rise event without a rising edge");

  AST_FALL_ONLY: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    typ == ppi_pkg::PPI_EV_FALL && (!prev || cur) |-> !event_hit)
    else $error("Fall event without a falling edge");

  AST_PREV_TRACK: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    1'b1 |=> gen_prev_q == $past(gen_i))
    else $error("Previous generator level not kept");

  AST_MASK_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
    menable_q == `PPI_ALL_CHAN && invert_q == `PPI_RST_CHAN |=> pwm_o == $past(mlevel_q))
    else $error("Mask level not on pins");

  AST_MASK_INVERT: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
    menable_q == `PPI_ALL_CHAN && invert_q == `PPI_ALL_CHAN |=> pwm_o == ~$past(mlevel_q))
    else $error("Mask level not inverted on pins");

  AST_CTRL_RESET: assert property (@(posedge clk_i)
    rst_i |=> ctrl_q == `PPI_RST_BYTE && !flag_q && !irq_o)
    else $error("Event control not cleared by reset");

  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    s_bus_take |=> s_ack_pulse)
    else $error("Acknowledge not a single cycle pulse");

  AST_ACK_CAUSE: assert property (@(posedge clk_i) disable iff (rst_i)
    !req |=> !wb_ack_o)
    else $error("Acknowledge without a request");

  AST_ACK_NO_REPEAT: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge held two cycles");

  AST_DAT_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == `PPI_RST_BYTE)
    else $error("Read data shown outside acknowledge");

  AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    1'b1 |-> irq_o == (flag_q && imask_q))
    else $error("Interrupt does not follow unmasked flag");

  AST_READ_STATUS: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    req && !wb_we_i && wb_adr_i == `PPI_OFF_EVENT_STATUS |=> wb_dat_o == {7'h00, $past(flag_q)})
    else $error("Status read does not show flag");

  AST_READ_INVERT: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    req && !wb_we_i && wb_adr_i == `PPI_OFF_OUTPUT_INVERT |=> wb_dat_o == {2'h0, $past(invert_q)})
    else $error("Invert read does not show invert bits");
endmodule : ppi_top
`default_nettype wire

// ==== tb/ppi_power_stage.sv ====
// Power stage model latching its pin levels
`default_nettype none
module ppi_power_stage (
  input  wire logic       clk_i,
  input  wire logic [5:0] pin_i,
  output logic      [5:0] seen_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_i) seen_o <= pin_i;
endmodule : ppi_power_stage
`default_nettype wire

// ==== tb/test_ppi_top.sv ====
// Testbench for the PWM polarity and period event block
`default_nettype none
module test_ppi_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i, rst_i, we, cyc, ca, pc, pe, ack, irq;
  logic [7:0] adr, dat, rd, q;
  logic [5:0] gen, pwm, seen;
  int         fail_count, check_count;
  ppi_top u_ppi_top (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat), .wb_we_i(we),
    .wb_sel_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rd), .wb_ack_o(ack), .gen_i(gen),
    .centre_aligned_i(ca), .period_centre_i(pc), .period_end_i(pe), .pwm_o(pwm), .irq_o(irq));
  ppi_power_stage u_ppi_power_stage (.clk_i(clk_i), .pin_i(pwm), .seen_o(seen));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      fail_count++;
      stop_test();
    end
    q = rd;
    cyc <= 1'b0;
  endtask : bus
  task automatic drive(input logic [5:0] g, input logic [1:0] p);
    @(posedge clk_i);
    gen <= g;
    {pe, pc} <= p;
    @(posedge clk_i);
    {pe, pc} <= 2'h0;
    repeat (3) @(posedge clk_i);
  endtask : drive
  task automatic t_pins;
    bus(0, 8'hd6, 8'h00);
    chk(q, 8'h00, "inv");
    bus(0, 8'hb7, 8'h00);
    chk(q, 8'h00, "ctl");
    chk({2'h0, seen}, 8'h2a, "pins");
    bus(0, 8'h10, 8'h00);
    chk(q, 8'h00, "unmapped");
    bus(1, 8'hd6, 8'h0f);
    repeat (3) @(posedge clk_i);
    chk({2'h0, seen}, 8'h25, "invpins");
    bus(0, 8'hff, 8'h00);
    chk(q, 8'h25, "pinstate");
    bus(1, 8'hfb, 8'h03);
    bus(1, 8'hfc, 8'h01);
    repeat (3) @(posedge clk_i);
    chk({2'h0, seen}, 8'h26, "mask");
    bus(1, 8'hfb, 8'h00);
  endtask : t_pins
  task automatic t_edge;
    for (int t = 0; t < 2; t++) begin
      for (int s = 0; s < 8; s++) begin
        bus(1, 8'hb7, {2'h0, t[1:0], 1'b0, s[2:0]});
        drive(6'h00, 2'h0);
        bus(1, 8'hfd, 8'h01);
        drive(6'h01 << ((s > 5) ? 0 : s), 2'h0);
        repeat (8) @(posedge clk_i);
        bus(0, 8'hfd, 8'h00);
        chk(q, {7'h0, t == 1}, "rise");
        bus(1, 8'hfd, 8'h01);
        drive(6'h00, 2'h0);
        bus(0, 8'hfd, 8'h00);
        chk(q, {7'h0, t == 0}, "fall");
      end
    end
  endtask : t_edge
  task automatic t_period;
    for (int t = 2; t < 4; t++) begin
      for (int a = 0; a < 4; a++) begin
        bus(1, 8'hb7, {2'h0, t[1:0], 4'h0});
        ca <= a[1];
        bus(1, 8'hfd, 8'h01);
        drive(6'h00, 2'h1 << a[0]);
        bus(0, 8'hfd, 8'h00);
        chk(q, {7'h0, a[1] && t == 2 + a[0]}, "period");
      end
    end
    bus(1, 8'hfd, 8'h01);
    bus(1, 8'hfe, 8'h01);
    repeat (3) @(posedge clk_i);
    chk({7'h0, irq}, 8'h00, "irqidle");
    drive(6'h00, 2'h2);
    chk({7'h0, irq}, 8'h01, "irq");
    bus(1, 8'hfd, 8'h01);
    repeat (3) @(posedge clk_i);
    chk({7'h0, irq}, 8'h00, "irqclr");
    bus(1, 8'hfe, 8'h00);
    drive(6'h00, 2'h2);
    chk({7'h0, irq}, 8'h00, "irqmask");
  endtask : t_period
  initial begin
    fail_count = 0;
    check_count = 0;
    rst_i = 1'b1;
    {cyc, we, ca, pc, pe} = 5'h00;
    adr = 8'h00;
    dat = 8'h00;
    gen = 6'h2a;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_pins();
    t_edge();
    t_period();
    stop_test();
  end
endmodule : test_ppi_top
`default_nettype wire
